// ===== sfb_flash_boot_master.sv
// serial flash boot reader: system-side request port, link-side serial master
`timescale 1ns/1ps
module sfb_flash_boot_master #(
  parameter int LINK_CLK_KHZ = sfb_pkg::SFB_LINK_KHZ,
  parameter int FLASH_MBIT   = sfb_pkg::SFB_MAX_MBIT
) (
  // system clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  // link clock, drives the serial master
  input  wire logic             i_link_clk,
  // read request
  input  wire logic             i_req_valid,
  input  wire sfb_pkg::sfb_req_s i_req,
  output logic                  o_req_ready,
  input  wire logic             i_abort,
  // read data stream
  output logic                  o_rd_valid,
  output sfb_pkg::sfb_rd_s      o_rd,
  // status
  output logic                  o_busy,
  output logic [sfb_pkg::SFB_LEN_W:0] o_byte_count,
  // flash pins
  output logic                  o_flash_sclk,
  output logic                  o_flash_select_n,
  output logic                  o_flash_dout,
  input  wire logic             i_flash_din
);

  import sfb_pkg::*;

  // divider window that keeps the serial clock inside its frequency range
  localparam int DIV_CEIL  = (LINK_CLK_KHZ + 2 * SFB_F_MAX_KHZ - 1) / (2 * SFB_F_MAX_KHZ);
  localparam int DIV_LO_I  = (DIV_CEIL < 2) ? 2 : DIV_CEIL;
  localparam int DIV_FLR   = LINK_CLK_KHZ / (2 * SFB_F_MIN_KHZ);
  localparam int DIV_HI_I  = (DIV_FLR < DIV_LO_I) ? DIV_LO_I : DIV_FLR;
  localparam logic [SFB_DIV_W-1:0] DIV_LO = SFB_DIV_W'(DIV_LO_I);
  localparam logic [SFB_DIV_W-1:0] DIV_HI = SFB_DIV_W'(DIV_HI_I);

  // byte address mask for the fitted flash size
  localparam int MBIT_I = (FLASH_MBIT < SFB_MIN_MBIT) ? SFB_MIN_MBIT :
                          (FLASH_MBIT > SFB_MAX_MBIT) ? SFB_MAX_MBIT : FLASH_MBIT;
  localparam logic [SFB_ADDR_W-1:0] ADDR_MASK = SFB_ADDR_W'(MBIT_I * SFB_MBIT_BYTES - 1);

  // half-period count limited to the legal window
  function automatic logic [SFB_DIV_W-1:0] clamp_div(input logic [SFB_DIV_W-1:0] d);
    logic [SFB_DIV_W-1:0] r;
    r = d;
    if (d < DIV_LO) begin
      r = DIV_LO;
    end else if (d > DIV_HI) begin
      r = DIV_HI;
    end
    return r;
  endfunction : clamp_div

  sfb_link_s link_reg;
  sfb_link_s link_next;
  sfb_sys_s  sys_reg;
  sfb_sys_s  sys_next;

  logic link_rst_b;
  logic req_tgl_s;
  logic ack_tgl_s;
  logic abort_tgl_s;
  logic din_s;
  logic byte_tgl_s;
  logic done_tgl_s;

  // link reset: asserted at once, released on the link clock
  sfb_sync2 #(.WIDTH(1)) u_link_rst (
    .i_clk   (i_link_clk),
    .i_rst_b (i_rst_b),
    .i_d     (1'b1),
    .o_q     (link_rst_b)
  );

  // system toggles and flash data into the link domain
  sfb_sync2 #(.WIDTH(4)) u_to_link (
    .i_clk   (i_link_clk),
    .i_rst_b (link_rst_b),
    .i_d     ({sys_reg.req_tgl, sys_reg.ack_tgl, sys_reg.abort_tgl, i_flash_din}),
    .o_q     ({req_tgl_s, ack_tgl_s, abort_tgl_s, din_s})
  );

  // link toggles into the system domain
  sfb_sync2 #(.WIDTH(2)) u_to_sys (
    .i_clk   (i_sys_clk),
    .i_rst_b (i_rst_b),
    .i_d     ({link_reg.byte_tgl, link_reg.done_tgl}),
    .o_q     ({byte_tgl_s, done_tgl_s})
  );

  // ---------------- link domain ----------------
  logic                    half_done;
  logic                    waiting;
  logic [SFB_HDR_BITS-1:0] hdr;

  always_comb begin
    link_next = link_reg;
    half_done = (link_reg.half_cnt == link_reg.div - 1'b1);
    waiting   = (ack_tgl_s != link_reg.byte_tgl);
    // address masked to the fitted flash size
    hdr       = {SFB_CMD_READ, sys_reg.req.addr & ADDR_MASK};

    if (abort_tgl_s != link_reg.abort_seen) begin
      link_next.abort_seen = abort_tgl_s;
      link_next.abort_pend = (link_reg.st == LS_RUN);
    end

    unique case (link_reg.st)
      LS_IDLE: begin
        link_next.sclk       = 1'b1;
        link_next.cs_n       = 1'b1;
        link_next.abort_pend = 1'b0;
        // request word is held stable by the system side until done
        if (req_tgl_s != link_reg.req_seen) begin
          link_next.req_seen   = req_tgl_s;
          link_next.div        = clamp_div(sys_reg.req.clk_div);
          link_next.bytes_left = sys_reg.req.len_m1;
          link_next.half_cnt   = '0;
          link_next.fall_idx   = 6'h01;
          link_next.bit_cnt    = 3'h0;
          // select falls with the first falling edge
          link_next.sclk       = 1'b0;
          link_next.cs_n       = 1'b0;
          link_next.sdo        = hdr[SFB_HDR_BITS-1];
          link_next.shift_out  = {hdr[SFB_HDR_BITS-2:0], 1'b0};
          link_next.st         = LS_RUN;
        end
      end

      LS_RUN: begin
        if (!half_done) begin
          link_next.half_cnt = link_reg.half_cnt + 1'b1;
        end else if (!link_reg.sclk) begin
          link_next.sclk     = 1'b1;
          link_next.half_cnt = '0;
        end else if (!waiting) begin
          // serial clock held high while the latest byte waits for its ack
          link_next.sclk     = 1'b0;
          link_next.half_cnt = '0;
          if (link_reg.fall_idx < SFB_SAMPLE_START) begin
            link_next.fall_idx = link_reg.fall_idx + 1'b1;
          end
          // next header bit on the falling edge
          if (link_reg.fall_idx < SFB_HDR_LAST) begin
            link_next.sdo       = link_reg.shift_out[SFB_HDR_BITS-1];
            link_next.shift_out = {link_reg.shift_out[SFB_HDR_BITS-2:0], 1'b0};
          end else begin
            link_next.sdo = 1'b0;
          end
          // sample on falling edge, one period after launch
          // flash launched this bit on the previous falling edge
          if (link_reg.fall_idx >= SFB_SAMPLE_START) begin
            link_next.rx      = {link_reg.rx[6:0], din_s};
            link_next.bit_cnt = link_reg.bit_cnt + 1'b1;
            if (link_reg.bit_cnt == 3'h7) begin
              link_next.rd.data  = {link_reg.rx[6:0], din_s};
              link_next.rd.last  = (link_reg.bytes_left == '0) || link_reg.abort_pend;
              link_next.byte_tgl = ~link_reg.byte_tgl;
              link_next.bytes_left = link_reg.bytes_left - 1'b1;
              if (link_reg.bytes_left == '0) begin
                // select returns high after the last bit
                link_next.cs_n = 1'b1;
                link_next.st   = LS_TAIL;
              end
            end
          end
          // abort ends the frame on a falling edge too
          if (link_reg.abort_pend) begin
            link_next.cs_n       = 1'b1;
            link_next.sdo        = 1'b0;
            link_next.abort_pend = 1'b0;
            link_next.st         = LS_TAIL;
          end
        end
      end

      LS_TAIL: begin
        if (!half_done) begin
          link_next.half_cnt = link_reg.half_cnt + 1'b1;
        end else if (!link_reg.sclk) begin
          link_next.sclk     = 1'b1;
          link_next.half_cnt = '0;
        end else if (!waiting) begin
          link_next.done_tgl = ~link_reg.done_tgl;
          link_next.st       = LS_IDLE;
        end
      end

      default: begin
        link_next = SFB_LINK_RST;
      end
    endcase
  end

  // select and data pins change only with the falling-edge updates above
  always_ff @(posedge i_link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      link_reg <= SFB_LINK_RST;
    end else begin
      link_reg <= link_next;
    end
  end

  // ---------------- system domain ----------------
  always_comb begin
    sys_next          = sys_reg;
    sys_next.rd_valid = 1'b0;

    // byte word held stable by the link until this ack returns
    if (byte_tgl_s != sys_reg.byte_seen) begin
      sys_next.byte_seen  = byte_tgl_s;
      sys_next.rd         = link_reg.rd;
      sys_next.rd_valid   = 1'b1;
      sys_next.ack_tgl    = ~sys_reg.ack_tgl;
      sys_next.byte_count = sys_reg.byte_count + 1'b1;
    end

    if (done_tgl_s != sys_reg.done_seen) begin
      sys_next.done_seen = done_tgl_s;
      sys_next.busy      = 1'b0;
    end

    if (i_abort && sys_reg.busy) begin
      sys_next.abort_tgl = ~sys_reg.abort_tgl;
    end

    if (i_req_valid && !sys_reg.busy) begin
      sys_next.req        = i_req;
      sys_next.req_tgl    = ~sys_reg.req_tgl;
      sys_next.busy       = 1'b1;
      sys_next.byte_count = '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_reg <= SFB_SYS_RST;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // outputs
  assign o_req_ready      = !sys_reg.busy;
  assign o_rd_valid       = sys_reg.rd_valid;
  assign o_rd             = sys_reg.rd;
  assign o_busy           = sys_reg.busy;
  assign o_byte_count     = sys_reg.byte_count;
  assign o_flash_sclk     = link_reg.sclk;
  assign o_flash_select_n = link_reg.cs_n;
  assign o_flash_dout     = link_reg.sdo;

endmodule : sfb_flash_boot_master

// ===== sfb_pkg.sv
// constants, types and reset values shared by the flash boot reader
package sfb_pkg;

  // read command and header layout
  localparam logic [7:0] SFB_CMD_READ     = 8'h03;
  localparam int         SFB_CMD_W        = 8;
  localparam int         SFB_ADDR_W       = 24;
  localparam int         SFB_HDR_BITS     = SFB_CMD_W + SFB_ADDR_W;
  localparam logic [5:0] SFB_HDR_LAST     = 6'(SFB_HDR_BITS);
  localparam logic [5:0] SFB_SAMPLE_START = 6'(SFB_HDR_BITS + 1);

  // transfer and divider field widths
  localparam int SFB_LEN_W = 16;
  localparam int SFB_DIV_W = 8;

  // serial clock limits in kHz, oscillator tolerance included
  localparam int SFB_F_MIN_KHZ = 1400;
  localparam int SFB_F_MAX_KHZ = 36000;

  // flash capacity range in megabits, bytes per megabit, and default link clock in kHz
  localparam int SFB_MIN_MBIT    = 1;
  localparam int SFB_MAX_MBIT    = 128;
  localparam int SFB_MBIT_BYTES  = 131072;
  localparam int SFB_LINK_KHZ    = 8000;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_RUN  = 2'b01,
    LS_TAIL = 2'b10
  } sfb_link_st_e;

  // one read request: divider, start byte address, byte count minus one
  typedef struct packed {
    logic [SFB_DIV_W-1:0]  clk_div;
    logic [SFB_ADDR_W-1:0] addr;
    logic [SFB_LEN_W-1:0]  len_m1;
  } sfb_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } sfb_rd_s;

  // link-side state
  typedef struct packed {
    sfb_link_st_e           st;
    logic                   sclk;
    logic                   cs_n;
    logic                   sdo;
    logic [SFB_HDR_BITS-1:0] shift_out;
    logic [7:0]             rx;
    logic [SFB_DIV_W-1:0]   half_cnt;
    logic [SFB_DIV_W-1:0]   div;
    logic [5:0]             fall_idx;
    logic [2:0]             bit_cnt;
    logic [SFB_LEN_W-1:0]   bytes_left;
    logic                   abort_pend;
    logic                   byte_tgl;
    logic                   done_tgl;
    logic                   req_seen;
    logic                   abort_seen;
    sfb_rd_s                rd;
  } sfb_link_s;

  // system-side state
  typedef struct packed {
    logic                 busy;
    logic                 req_tgl;
    logic                 ack_tgl;
    logic                 abort_tgl;
    logic                 byte_seen;
    logic                 done_seen;
    logic                 rd_valid;
    logic [SFB_LEN_W:0]   byte_count;
    sfb_req_s             req;
    sfb_rd_s              rd;
  } sfb_sys_s;

  localparam sfb_link_s SFB_LINK_RST = '{st: LS_IDLE, sclk: 1'b1, cs_n: 1'b1, default: '0};
  localparam sfb_sys_s  SFB_SYS_RST  = '0;

endpackage : sfb_pkg

// ===== sfb_sync2.sv
// two-flop synchroniser, also used as a reset release synchroniser
`timescale 1ns/1ps
module sfb_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // data
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [1:0][WIDTH-1:0] pipe_reg;
  logic [1:0][WIDTH-1:0] pipe_next;

  always_comb begin
    pipe_next    = pipe_reg;
    pipe_next[0] = i_d;
    pipe_next[1] = pipe_reg[0];
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= pipe_next;
    end
  end

  assign o_q = pipe_reg[1];

endmodule : sfb_sync2

// ===== sfb_flash_boot_master_chk.sv
// port assertions for the flash boot reader
`timescale 1ns/1ps
module sfb_flash_boot_master_chk (
  // clocks and reset
  input wire logic                        i_sys_clk,
  input wire logic                        i_rst_b,
  input wire logic                        i_link_clk,
  // request and stream
  input wire logic                        i_req_valid,
  input wire logic                        o_req_ready,
  input wire logic                        o_rd_valid,
  input wire logic                        o_busy,
  input wire logic [sfb_pkg::SFB_LEN_W:0] o_byte_count,
  // flash pins
  input wire logic                        o_flash_sclk,
  input wire logic                        o_flash_select_n,
  input wire logic                        o_flash_dout
);
  import sfb_pkg::*;
  AST_SEL_FALL: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $fell(o_flash_select_n) |-> $fell(o_flash_sclk)) else $error("select fell off a clock fall");
  AST_SEL_RISE: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $rose(o_flash_select_n) |-> $fell(o_flash_sclk)) else $error("select rose off a clock fall");
  AST_DOUT_FALL: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $changed(o_flash_dout) |-> $fell(o_flash_sclk)) else $error("data changed off a clock fall");
  AST_LOW_TWO: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $fell(o_flash_sclk) |=> !o_flash_sclk ##1 o_flash_sclk) else $error("low phase not two clocks");
  AST_HIGH_MIN: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $rose(o_flash_sclk) |=> o_flash_sclk) else $error("high phase too short");
  AST_IDLE_HIGH: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    o_flash_select_n [*3] |-> o_flash_sclk) else $error("clock not idle high");
  AST_ACCEPT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_req_valid && o_req_ready |=> o_busy && !o_req_ready && o_byte_count == '0) else $error("accept");
  AST_RD_PULSE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_rd_valid |-> o_busy ##1 !o_rd_valid) else $error("byte strobe not a busy pulse");
  AST_COUNT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_rd_valid |-> o_byte_count == $past(o_byte_count) + 1'b1) else $error("byte count step");
  cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_rd_valid);
  cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $fell(o_busy));
  cover property (@(posedge i_link_clk) disable iff (!i_rst_b) $rose(o_flash_select_n));
endmodule : sfb_flash_boot_master_chk

bind sfb_flash_boot_master sfb_flash_boot_master_chk sfb_flash_boot_master_chk_inst (
  .i_sys_clk, .i_rst_b, .i_link_clk, .i_req_valid, .o_req_ready, .o_rd_valid,
  .o_busy, .o_byte_count, .o_flash_sclk, .o_flash_select_n, .o_flash_dout);

// ===== sfb_flash_model.sv
// behavioural serial flash answering read commands
`timescale 1ns/1ps
module sfb_flash_model (
  // serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // last captured header
  output logic [31:0]      o_hdr
);
  int         rcnt;
  int         d;
  logic [7:0] b;
  initial begin
    o_miso = 1'b0;
    o_hdr  = '0;
    rcnt   = 0;
  end
  always @(posedge i_sclk) begin
    if (i_cs_n === 1'b0) begin
      if (rcnt < 32) o_hdr = {o_hdr[30:0], i_mosi};
      rcnt = rcnt + 1;
    end
  end
  always @(negedge i_sclk) begin
    if (i_cs_n === 1'b0 && rcnt >= 32) begin
      d = rcnt - 32;
      b = 8'(o_hdr[23:0] + 24'(d / 8));
      b = b ^ 8'((o_hdr[23:0] + 24'(d / 8)) >> 8) ^ 8'h5A;
      o_miso <= b[3'(7 - d % 8)];
    end
  end
  // released line shows the inverse of its last value
  always @(posedge i_cs_n) begin
    rcnt = 0;
    o_miso <= ~o_miso;
  end
endmodule : sfb_flash_model

// ===== sfb_flash_boot_master_tb.sv
// self-checking bench for the flash boot reader
`timescale 1ns/1ps
module sfb_flash_boot_master_tb;
  import sfb_pkg::*;
  logic                 i_sys_clk;
  logic                 i_rst_b;
  logic                 i_link_clk;
  logic                 i_req_valid;
  sfb_req_s             i_req;
  logic                 o_req_ready;
  logic                 i_abort;
  logic                 o_rd_valid;
  sfb_rd_s              o_rd;
  logic                 o_busy;
  logic [SFB_LEN_W:0]   o_byte_count;
  logic                 o_flash_sclk;
  logic                 o_flash_select_n;
  logic                 o_flash_dout;
  logic                 i_flash_din;
  logic [31:0]          hdr;
  int                   fail_count = 0;
  int                   cmp_count = 0;
  int                   cyc_cnt = 0;
  int                   got;

  sfb_flash_boot_master sfb_flash_boot_master_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_link_clk(i_link_clk),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .i_abort(i_abort),
    .o_rd_valid(o_rd_valid), .o_rd(o_rd), .o_busy(o_busy), .o_byte_count(o_byte_count),
    .o_flash_sclk(o_flash_sclk), .o_flash_select_n(o_flash_select_n),
    .o_flash_dout(o_flash_dout), .i_flash_din(i_flash_din));
  sfb_flash_model sfb_flash_model_inst (
    .i_sclk(o_flash_sclk), .i_cs_n(o_flash_select_n), .i_mosi(o_flash_dout),
    .o_miso(i_flash_din), .o_hdr(hdr));

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #37;
    forever #62.5 i_link_clk = ~i_link_clk;
  end

  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : exp_byte

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // one read request, collecting and judging bytes until idle
  task automatic run_read(input logic [7:0] dv, input logic [23:0] ad, input logic [15:0] lm,
                          input int ab_at, output int n);
    n = 0;
    i_req = '{clk_div: dv, addr: ad, len_m1: lm};
    i_req_valid = 1'b1;
    @(posedge i_sys_clk);
    #1 i_req_valid = 1'b0;
    while (o_busy === 1'b1) begin
      i_abort = (o_rd_valid === 1'b1) && (n + 1 == ab_at);
      if (o_rd_valid === 1'b1) begin
        chk("rd_data", 32'(exp_byte(ad + 24'(n))), 32'(o_rd.data));
        if (ab_at < 0) chk("rd_last", 32'(n == int'(lm)), 32'(o_rd.last));
        n++;
      end
      @(posedge i_sys_clk);
      #1;
    end
    i_abort = 1'b0;
  endtask : run_read

  task automatic s_reset();
    @(posedge i_sys_clk);
    #1;
    chk("ready", 32'h1, 32'(o_req_ready));
    chk("select_n", 32'h1, 32'(o_flash_select_n));
    chk("sclk", 32'h1, 32'(o_flash_sclk));
    chk("dout", 32'h0, 32'(o_flash_dout));
  endtask : s_reset

  task automatic s_read();
    run_read(8'h00, 24'hFFFFFC, 16'h0003, -1, got);
    chk("bytes", 32'h4, 32'(got));
    chk("byte_count", 32'h4, 32'(o_byte_count));
    chk("header", {SFB_CMD_READ, 24'hFFFFFC}, hdr);
    chk("select_n_end", 32'h1, 32'(o_flash_select_n));
  endtask : s_read

  task automatic s_abort();
    run_read(8'hFF, 24'h000100, 16'h0063, 2, got);
    chk("abort_bytes", 32'h2, 32'(got));
    chk("abort_header", {SFB_CMD_READ, 24'h000100}, hdr);
    chk("abort_select_n", 32'h1, 32'(o_flash_select_n));
    chk("abort_ready", 32'h1, 32'(o_req_ready));
  endtask : s_abort

  always @(posedge i_sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    i_rst_b = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    i_abort = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    #1 i_rst_b = 1'b1;
    s_reset();
    s_read();
    s_abort();
    final_report();
  end
endmodule : sfb_flash_boot_master_tb
